// ---- src/mcs_top.sv ----
// meter card command state: defaults, reset, identity, self-test, slot select
`timescale 1ns/1ps
module mcs_top
  import mcs_pkg::*;
#(
  parameter int unsigned MEAS_LEN = MEAS_CYCLES,
  parameter logic [15:0] OWN_SLOT = SLOT_POR,
  parameter logic [31:0] MODEL_ID = 32'h00ab_cd01, // arbitrary value
  parameter int unsigned BUF_DEPTH = 255
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  // mainframe slots: population by slot digit (extender 0 only)
  input wire logic [9:0] slot_populated_i,
  // self-test check outcomes
  input wire logic [TEST_STEPS-1:0] check_ok_i,
  // status outputs
  output logic busy_o,
  output logic meas_abort_o,
  output logic buf_flush_o,
  output logic irq_o
);
  // ==========================================================
  // address digit checks, used on the command and the persistent slot
  function automatic logic slot_valid(input logic [15:0] s);
    slot_valid = (s[15:12] <= EXT_MAX) && (s[11:8] <= 4'h9)
                 && (s[7:0] == 8'h00);
  endfunction : slot_valid

  // ==========================================================
  // command decode
  wire cmd_wr = wr_i && (addr_i == OFS_CMD);
  wire [3:0] op = wr_data_i[CMD_OP_LSB +: 4];
  wire has_val = wr_data_i[CMD_HASVAL_BIT];
  wire has_dest = wr_data_i[CMD_HASDEST_BIT];
  wire [7:0] val = wr_data_i[CMD_VAL_LSB +: 8];
  wire [15:0] dest_in = wr_data_i[CMD_DEST_LSB +: 16];

  logic [15:0] use_slot;
  logic [15:0] last_dest;
  // the attached destination steers this one command only
  wire [15:0] dest = has_dest ? dest_in : use_slot;
  wire dest_ok = slot_valid(dest);
  wire to_me = dest_ok && (dest == OWN_SLOT);
  // extender slots are not wired to this block, so they always read as empty
  wire populated = (dest[15:12] == 4'h0) && slot_populated_i[dest[11:8]];
  // new persistent slot carried in the value; a bad digit keeps the old one
  wire [15:0] use_req = {val, 8'h00};
  wire use_ok = slot_valid(use_req);

  wire do_cmd = cmd_wr && (op != OP_NOP);
  wire addr_err = do_cmd && (op != OP_USEQ) && !dest_ok;
  wire do_reset = do_cmd && (op == OP_RESET) && to_me;
  wire do_use = do_cmd && (op == OP_USE) && has_val && dest_ok && use_ok;
  wire do_ident = do_cmd && (op == OP_IDENT) && dest_ok;
  wire do_test = do_cmd && (op == OP_TEST) && to_me;
  wire do_func = do_cmd && (op == OP_FUNC) && to_me;
  wire do_nplc = do_cmd && (op == OP_NPLC) && to_me;
  wire do_term = do_cmd && (op == OP_TERM) && to_me;
  wire do_meas = do_cmd && (op == OP_MEAS) && to_me;

  // ==========================================================
  // control state
  mcs_state_type state;
  mcs_state_type next_state;
  logic [31:0] config_q;
  logic [31:0] next_config;
  logic [31:0] result;
  logic [7:0] rdg_count;
  logic [31:0] meas_cnt;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic test_done;
  logic test_pass;
  logic [2:0] test_step;

  wire meas_end = (state == ST_MEAS) && (meas_cnt == 32'(MEAS_LEN - 1));
  // a reset or a finished test both bring back the power-on settings
  wire restore = do_reset || test_done;

  // ==========================================================
  // self-test sequencer; card busy at start means a failed test
  mcs_selftest #(
    .STEP_CYCLES(TEST_STEP_CYCLES)
  ) u_selftest (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .start_i(do_test && (state != ST_TEST)),
    .busy_fail_i(state != ST_IDLE),
    .abort_i(do_reset),
    .check_ok_i(check_ok_i),
    .done_o(test_done),
    .pass_o(test_pass),
    .step_o(test_step)
  );

  // ==========================================================
  // next state: measurement runs MEAS_LEN cycles, one line cycle by default, whatever the integration code
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (do_test)
          next_state = ST_TEST;
        else if (do_meas)
          next_state = ST_MEAS;
      ST_MEAS:
        if (do_test)
          next_state = ST_TEST; // test will report a failure
        else if (meas_end)
          next_state = ST_IDLE;
      ST_TEST:
        if (test_done)
          next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    if (do_reset)
      next_state = ST_IDLE;
  end

  // setting updates; an omitted value takes the default
  always_comb
  begin
    next_config = config_q;
    if (restore)
      next_config = CONFIG_POR;
    else if (state != ST_TEST)
    begin
      if (do_func)
      begin
        next_config[1:0] = has_val ? val[1:0] : FUNC_DCV;
        next_config[2] = 1'b1; // autorange on by default
      end
      if (do_nplc)
        next_config[10:8] = has_val ? val[2:0] : NPLC_ONE;
      if (do_term)
        next_config[4:3] = has_val ? val[1:0] : TERM_EXT;
    end
  end

  // ==========================================================
  // state, settings and busy
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state <= ST_IDLE;
      config_q <= CONFIG_POR;
      busy_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      config_q <= next_config;
      busy_o <= (next_state != ST_IDLE);
    end
  end

  // integration timer; aborted by reset or a test
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || state != ST_MEAS)
      meas_cnt <= 32'h0000_0000;
    else
      meas_cnt <= meas_cnt + 32'h0000_0001;
  end

  // reading buffer count: saturates rather than wraps when full
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || restore)
      rdg_count <= 8'h00;
    else if (meas_end && rdg_count != 8'(BUF_DEPTH))
      rdg_count <= rdg_count + 8'h01;
  end

  // abort and flush pulses for the analog side
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      meas_abort_o <= 1'b0;
      buf_flush_o <= 1'b0;
    end
    else
    begin
      meas_abort_o <= do_reset && (state == ST_MEAS);
      buf_flush_o <= restore;
    end
  end

  // ==========================================================
  // persistent destination and last routed destination
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      use_slot <= SLOT_POR;
      last_dest <= SLOT_POR;
    end
    else
    begin
      if (do_use)
        use_slot <= use_req;
      else if (do_reset)
        use_slot <= SLOT_POR;
      // a new persistent slot is what a later bare query must report
      if (do_use)
        last_dest <= use_req;
      else if (do_cmd && op != OP_USEQ && dest_ok)
        last_dest <= dest;
    end
  end

  // ==========================================================
  // answer register: identity, test outcome, destination
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      result <= RES_TEST_OK;
    else if (do_ident)
      result <= populated ? MODEL_ID : RES_EMPTY_SLOT;
    else if (test_done)
      result <= test_pass ? RES_TEST_OK : RES_TEST_FAIL;
    else if (do_cmd && op == OP_USEQ)
      result <= {16'h0000, has_dest ? dest_in : last_dest};
  end

  // ==========================================================
  // interrupts: hardware set wins over a clear in the same cycle
  wire [IRQ_W-1:0] irq_set = {meas_end, addr_err,
                              test_done && !test_pass,
                              test_done && test_pass, do_cmd};
  wire irq_clr_wr = wr_i && (addr_i == OFS_IRQ_CLEAR);
  wire [IRQ_W-1:0] irq_clr = irq_clr_wr ? wr_data_i[IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      irq_status <= '0;
      irq_enable <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      if (wr_i && addr_i == OFS_IRQ_ENABLE)
        irq_enable <= wr_data_i[IRQ_W-1:0];
      irq_o <= |(((irq_status & ~irq_clr) | irq_set) & irq_enable);
    end
  end

  // ==========================================================
  // read mux; unmapped or write-only offsets read zero
  logic [31:0] rd_mux;
  always_comb
  begin
    case (addr_i)
      OFS_CONFIG: rd_mux = config_q;
      OFS_STATUS: rd_mux = {16'h0000, rdg_count, 1'b0, test_step, 1'b0,
                            state == ST_TEST, state == ST_MEAS, busy_o};
      OFS_USE: rd_mux = {16'h0000, use_slot};
      OFS_RESULT: rd_mux = result;
      OFS_IRQ_STATUS: rd_mux = {{(32-IRQ_W){1'b0}}, irq_status};
      OFS_IRQ_ENABLE: rd_mux = {{(32-IRQ_W){1'b0}}, irq_enable};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || !rd_i)
      rd_data_o <= 32'h0000_0000;
    else
      rd_data_o <= rd_mux;
  end
endmodule : mcs_top

// ---- src/mcs_pkg.sv ----
// constants for the meter configuration, self-test and slot select block
package mcs_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned LINE_HZ = 60;
  // one line cycle at the default line rate, rounded down
  localparam int unsigned MEAS_CYCLES = CLK_HZ / LINE_HZ;
  localparam int unsigned TEST_STEP_CYCLES = 16;
  localparam int unsigned TEST_STEPS = 5;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_USE = 8'h0c;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1c;

  // ==========================================================
  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_HASVAL_BIT = 4;
  localparam int CMD_HASDEST_BIT = 5;
  localparam int CMD_VAL_LSB = 8;
  localparam int CMD_DEST_LSB = 16;

  // command opcodes
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_RESET = 4'h1;
  localparam logic [3:0] OP_IDENT = 4'h2;
  localparam logic [3:0] OP_TEST = 4'h3;
  localparam logic [3:0] OP_USE = 4'h4;
  localparam logic [3:0] OP_USEQ = 4'h5;
  localparam logic [3:0] OP_FUNC = 4'h6;
  localparam logic [3:0] OP_NPLC = 4'h7;
  localparam logic [3:0] OP_MEAS = 4'h8;
  localparam logic [3:0] OP_TERM = 4'h9;

  // ==========================================================
  // power-on settings (config register layout)
  localparam logic [1:0] FUNC_DCV = 2'h0;
  localparam logic [2:0] NPLC_ONE = 3'h3;
  localparam logic [7:0] RDGS_PER_TRIG = 8'h01;
  localparam logic [1:0] TERM_EXT = 2'h0;
  // config: [1:0] func,[2] autorange,[4:3] term,[5] trig hold,[6] ocomp,
  // [7] autozero,[10:8] integration code,[11] 60 Hz line,[23:16] readings
  localparam logic [31:0] CONFIG_POR = 32'h0001_0ba4;

  // ==========================================================
  // slot address (four bcd digits: extender, slot, 0, 0)
  localparam logic [3:0] EXT_MAX = 4'h7;
  localparam logic [15:0] SLOT_POR = 16'h0100;

  // ==========================================================
  // answers and interrupt bits
  localparam logic [31:0] RES_TEST_OK = 32'h0000_0000;
  localparam logic [31:0] RES_TEST_FAIL = 32'hffff_feac; // -340
  localparam logic [31:0] RES_EMPTY_SLOT = 32'h0000_0000;
  localparam int IRQ_W = 5;
  localparam int IRQ_CMD = 0;
  localparam int IRQ_TPASS = 1;
  localparam int IRQ_TFAIL = 2;
  localparam int IRQ_ADDR = 3;
  localparam int IRQ_MEAS = 4;

  // ==========================================================
  // state types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEAS = 3'b010,
    ST_TEST = 3'b100
  } mcs_state_type;

  typedef enum logic [2:0] {
    TS_IDLE = 3'b001,
    TS_RUN = 3'b010,
    TS_DONE = 3'b100
  } mcs_tstate_type;
endpackage : mcs_pkg

// ---- src/mcs_selftest.sv ----
// five-step self-test sequencer for the meter card
`timescale 1ns/1ps
module mcs_selftest
  import mcs_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = TEST_STEP_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // control
  input wire logic start_i,
  input wire logic busy_fail_i,
  input wire logic abort_i,
  // check outcomes, index 0 = link ... index 4 = calibration present
  input wire logic [TEST_STEPS-1:0] check_ok_i,
  // outcome
  output logic done_o,
  output logic pass_o,
  output logic [2:0] step_o
);
  // ==========================================================
  // sequencer
  mcs_tstate_type state;
  logic [15:0] cnt;
  logic fail;
  wire step_end = (cnt == 16'(STEP_CYCLES - 1));
  wire last_step = (step_o == 3'(TEST_STEPS - 1));

  // steps run strictly in order; a busy start fails without running
  always_ff @(posedge core_clk_i)
  begin
    done_o <= 1'b0;
    if (srst_i || abort_i)
    begin
      state <= TS_IDLE;
      cnt <= 16'h0000;
      step_o <= 3'h0;
      fail <= 1'b0;
      pass_o <= 1'b0;
    end
    else
    begin
      case (state)
        TS_IDLE:
          if (start_i)
          begin
            step_o <= 3'h0;
            cnt <= 16'h0000;
            fail <= busy_fail_i;
            state <= busy_fail_i ? TS_DONE : TS_RUN;
          end
        TS_RUN:
          if (step_end)
          begin
            cnt <= 16'h0000;
            // calibration step only looks for presence of constants
            if (!check_ok_i[step_o])
              fail <= 1'b1;
            if (last_step)
              state <= TS_DONE;
            else
              step_o <= step_o + 3'h1;
          end
          else
            cnt <= cnt + 16'h0001;
        TS_DONE:
        begin
          done_o <= 1'b1;
          pass_o <= !fail;
          state <= TS_IDLE;
        end
        default: state <= TS_IDLE;
      endcase
    end
  end
endmodule : mcs_selftest

// ---- tb/mcs_top_props.sv ----
// assertion checker for the meter card command block
`timescale 1ns/1ps
module mcs_top_props
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o,
  // slots and check outcomes
  input wire logic [9:0] slot_populated_i,
  input wire logic [TEST_STEPS-1:0] check_ok_i,
  // status outputs
  input wire logic busy_o,
  input wire logic meas_abort_o,
  input wire logic buf_flush_o,
  input wire logic irq_o
);
  // ==========================================================
  // clocking and enable mirror
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  logic [IRQ_W-1:0] en_q;

  // mirror of the enable register, so masking can be judged
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      en_q <= '0;
    else if (wr_i && (addr_i == OFS_IRQ_ENABLE))
      en_q <= wr_data_i[IRQ_W-1:0];
  end

  // ==========================================================
  // relations at the ports
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
    else $error("read data outside its one-cycle slot");
  AST_RD_WONLY: assert property ($past(rd_i && (addr_i == OFS_IRQ_CLEAR))
    |-> rd_data_o == 32'h0)
    else $error("write-only clear place read back nonzero");
  AST_ABORT_PULSE: assert property (meas_abort_o |=> !meas_abort_o)
    else $error("abort pulse longer than one cycle");
  AST_FLUSH_PULSE: assert property (buf_flush_o |=> !buf_flush_o)
    else $error("flush pulse longer than one cycle");
  AST_ABORT_BUSY: assert property (meas_abort_o |-> $past(busy_o) && !busy_o)
    else $error("abort without a running measurement or busy kept");
  AST_BUSY_CAUSE: assert property ($rose(busy_o) |-> $past(wr_i && (addr_i == OFS_CMD)))
    else $error("busy rose without a command one cycle before");
  AST_RESET_QUIET: assert property ($fell(srst_i) |-> !busy_o && !irq_o && !meas_abort_o)
    else $error("outputs active right after reset");
  AST_IRQ_MASKED: assert property ((en_q == '0) && ($past(en_q) == '0) |-> !irq_o)
    else $error("interrupt raised with every source masked");
endmodule : mcs_top_props

bind mcs_top mcs_top_props mcs_top_props_i (
  .core_clk_i(core_clk_i),
  .srst_i(srst_i),
  .addr_i(addr_i),
  .wr_data_i(wr_data_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rd_data_o(rd_data_o),
  .slot_populated_i(slot_populated_i),
  .check_ok_i(check_ok_i),
  .busy_o(busy_o),
  .meas_abort_o(meas_abort_o),
  .buf_flush_o(buf_flush_o),
  .irq_o(irq_o)
);

// ---- tb/mcs_ctrl_model.sv ----
// mainframe controller model: register cycles and command words
`timescale 1ns/1ps
module mcs_ctrl_model
  import mcs_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // register port toward the card
  output logic [7:0] addr_o,
  output logic [31:0] wr_data_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [31:0] rd_data_i
);
  // ==========================================================
  // bus cycles
  initial
  begin
    addr_o = 8'h00;
    wr_data_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // released lines show the inverse, so a stale value is never trusted
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    wr_data_o <= d;
    wr_o <= 1'b1;
    @(posedge core_clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wr_data_o <= ~d;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge core_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge core_clk_i);
    d = rd_data_i;
  endtask : rd

  // command word; a nonzero destination is attached as extender, slot, 0, 0
  function automatic logic [31:0] cw(input logic [3:0] op, input logic hv,
    input logic [7:0] v, input logic [15:0] d);
    return {d, v, 2'b00, d != 16'h0, hv, op};
  endfunction : cw

  task automatic send(input logic [3:0] op, input logic hv, input logic [7:0] v,
    input logic [15:0] d);
    wr(OFS_CMD, cw(op, hv, v, d));
  endtask : send
endmodule : mcs_ctrl_model

// ---- tb/mcs_top_tb.sv ----
// self-checking bench for the meter card command block
`timescale 1ns/1ps
module mcs_top_tb;
  import mcs_pkg::*;
  // ==========================================================
  // signals and instances
  localparam logic [31:0] MID = 32'h0012_3401; // arbitrary model code
  typedef struct {
    logic [31:0] cmd;
    logic [7:0] adr;
    logic [31:0] exp;
  } mcs_row_type;
  logic core_clk_i, srst_i, wr_i, rd_i, busy_o, meas_abort_o, buf_flush_o, irq_o;
  logic [7:0] addr_i;
  logic [31:0] wr_data_i, rd_data_o, got;
  logic [9:0] slot_populated_i;
  logic [TEST_STEPS-1:0] check_ok_i;
  int fails = 0;
  int n_checks = 0;
  int n_abort = 0;
  int n_flush = 0;
  mcs_row_type rows [8];

  // short measurement keeps the run brief
  mcs_top #(.MEAS_LEN(20), .MODEL_ID(MID)) mcs_top_i (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .slot_populated_i(slot_populated_i),
    .check_ok_i(check_ok_i), .busy_o(busy_o), .meas_abort_o(meas_abort_o),
    .buf_flush_o(buf_flush_o), .irq_o(irq_o));
  mcs_ctrl_model mcs_ctrl_model_i (.core_clk_i(core_clk_i), .addr_o(addr_i),
    .wr_data_o(wr_data_i), .wr_o(wr_i), .rd_o(rd_i), .rd_data_i(rd_data_o));

  // clock and pulse counters
  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    n_abort <= n_abort + int'(meas_abort_o === 1'b1);
    n_flush <= n_flush + int'(buf_flush_o === 1'b1);
  end

  // ==========================================================
  // compare, wait and closing tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // bounded poll, so a lost event cannot hang the run
  task automatic wait_irq(input int b);
    logic [31:0] s;
    s = '0;
    for (int i = 0; (i < 100) && (s[b] !== 1'b1); i++)
      mcs_ctrl_model_i.rd(OFS_IRQ_STATUS, s);
    chk(32'(s[b]), 32'h1);
  endtask : wait_irq

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_checks, fails);
    if ((fails == 0) && (n_checks > 0))
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  // watchdog: the sequence needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    fails++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    srst_i = 1'b1;
    slot_populated_i = 10'h002;
    check_ok_i = 5'h1f;
    rows[0] = '{mcs_ctrl_model_i.cw(OP_NOP, 1'b0, 8'h0, 16'h0), OFS_CONFIG, CONFIG_POR};
    rows[1] = '{mcs_ctrl_model_i.cw(OP_NOP, 1'b0, 8'h0, 16'h0), OFS_USE, 32'(SLOT_POR)};
    rows[2] = '{mcs_ctrl_model_i.cw(OP_IDENT, 1'b0, 8'h0, 16'h0100), OFS_RESULT, MID};
    rows[3] = '{mcs_ctrl_model_i.cw(OP_IDENT, 1'b0, 8'h0, 16'h0200), OFS_RESULT, RES_EMPTY_SLOT};
    rows[4] = '{mcs_ctrl_model_i.cw(OP_IDENT, 1'b0, 8'h0, 16'h1100), OFS_RESULT, 32'h0};
    rows[5] = '{mcs_ctrl_model_i.cw(OP_USEQ, 1'b0, 8'h0, 16'h0300), OFS_RESULT, 32'h0300};
    rows[6] = '{mcs_ctrl_model_i.cw(OP_NOP, 1'b0, 8'h0, 16'h0), OFS_USE, 32'(SLOT_POR)};
    rows[7] = '{mcs_ctrl_model_i.cw(OP_MEAS, 1'b0, 8'h0, 16'h8100), OFS_IRQ_STATUS, 32'h9};
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    foreach (rows[i])
    begin
      mcs_ctrl_model_i.wr(OFS_CMD, rows[i].cmd);
      mcs_ctrl_model_i.rd(rows[i].adr, got);
      chk(got, rows[i].exp);
    end
    // unmapped and write-only places read as zero
    mcs_ctrl_model_i.rd(8'h40, got);
    chk(got, 32'h0);
    mcs_ctrl_model_i.rd(OFS_IRQ_CLEAR, got);
    chk(got, 32'h0);
    mcs_ctrl_model_i.wr(OFS_IRQ_CLEAR, 32'h1f);
    // a value given, then left out, falls back to the default
    mcs_ctrl_model_i.send(OP_FUNC, 1'b1, 8'h01, 16'h0);
    mcs_ctrl_model_i.rd(OFS_CONFIG, got);
    chk(got, {CONFIG_POR[31:2], 2'h1});
    mcs_ctrl_model_i.send(OP_FUNC, 1'b0, 8'h00, 16'h0);
    mcs_ctrl_model_i.rd(OFS_CONFIG, got);
    chk(got, CONFIG_POR);
    // reset in mid-measurement aborts and flushes
    mcs_ctrl_model_i.send(OP_MEAS, 1'b0, 8'h00, 16'h0);
    @(negedge core_clk_i);
    chk(32'(busy_o), 32'h1);
    mcs_ctrl_model_i.send(OP_RESET, 1'b0, 8'h00, 16'h0);
    repeat (2) @(negedge core_clk_i);
    chk(32'(busy_o), 32'h0);
    chk(32'(n_abort), 32'h1);
    chk(32'(n_flush), 32'h1);
    // persistent slot elsewhere; attached slot routes one command only
    mcs_ctrl_model_i.send(OP_USE, 1'b1, 8'h02, 16'h0);
    mcs_ctrl_model_i.rd(OFS_USE, got);
    chk(got, 32'h0200);
    // a slot digit above nine is refused; a bare query reports the last routed destination
    mcs_ctrl_model_i.send(OP_USE, 1'b1, 8'h0a, 16'h0);
    mcs_ctrl_model_i.send(OP_USEQ, 1'b0, 8'h00, 16'h0);
    mcs_ctrl_model_i.rd(OFS_RESULT, got);
    chk(got, 32'h0200);
    mcs_ctrl_model_i.send(OP_MEAS, 1'b0, 8'h00, 16'h0);
    @(negedge core_clk_i);
    chk(32'(busy_o), 32'h0);
    mcs_ctrl_model_i.send(OP_MEAS, 1'b0, 8'h00, SLOT_POR);
    @(negedge core_clk_i);
    chk(32'(busy_o), 32'h1);
    mcs_ctrl_model_i.rd(OFS_USE, got);
    chk(got, 32'h0200);
    // self-test while busy must fail
    mcs_ctrl_model_i.send(OP_TEST, 1'b0, 8'h00, SLOT_POR);
    wait_irq(IRQ_TFAIL);
    mcs_ctrl_model_i.rd(OFS_RESULT, got);
    chk(got, RES_TEST_FAIL);
    repeat (30) @(negedge core_clk_i);
    chk(32'(busy_o), 32'h0);
    // clean pass: settings changed before, defaults after
    mcs_ctrl_model_i.wr(OFS_IRQ_ENABLE, 32'h2);
    mcs_ctrl_model_i.send(OP_RESET, 1'b0, 8'h00, SLOT_POR);
    mcs_ctrl_model_i.send(OP_FUNC, 1'b1, 8'h01, 16'h0);
    mcs_ctrl_model_i.send(OP_TEST, 1'b0, 8'h00, 16'h0);
    wait_irq(IRQ_TPASS);
    mcs_ctrl_model_i.rd(OFS_RESULT, got);
    chk(got, RES_TEST_OK);
    mcs_ctrl_model_i.rd(OFS_CONFIG, got);
    chk(got, CONFIG_POR);
    chk(32'(irq_o), 32'h1);
    // mask, unmask, then clear the pending event
    mcs_ctrl_model_i.wr(OFS_IRQ_ENABLE, 32'h0);
    repeat (2) @(negedge core_clk_i);
    chk(32'(irq_o), 32'h0);
    mcs_ctrl_model_i.wr(OFS_IRQ_ENABLE, 32'h2);
    repeat (2) @(negedge core_clk_i);
    chk(32'(irq_o), 32'h1);
    mcs_ctrl_model_i.wr(OFS_IRQ_CLEAR, 32'h1f);
    repeat (2) @(negedge core_clk_i);
    chk(32'(irq_o), 32'h0);
    // calibration constants missing fails the last check
    @(posedge core_clk_i);
    check_ok_i <= 5'h0f;
    mcs_ctrl_model_i.send(OP_TEST, 1'b0, 8'h00, 16'h0);
    wait_irq(IRQ_TFAIL);
    mcs_ctrl_model_i.rd(OFS_RESULT, got);
    chk(got, RES_TEST_FAIL);
    // one flush per reset command and per finished test
    chk(32'(n_flush), 32'h5);
    // a second power-up in mid-run brings back every default
    mcs_ctrl_model_i.send(OP_FUNC, 1'b1, 8'h02, 16'h0);
    srst_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    mcs_ctrl_model_i.rd(OFS_CONFIG, got);
    chk(got, CONFIG_POR);
    wrap_up();
  end
endmodule : mcs_top_tb
